// [include/ub2i_params.svh]
// Constants and timing counts for the USB to two-wire slave data bridge.
// Overview of operation
// - Host bytes enter the transmit buffer for master.
// - Master-written bytes enter receive buffer for host.
// - Forward receive buffer when full or timer expires.
// - Slave only; never drives clock; baud ignored.
// - Config bit sampled each enumeration, reported to host.
// - Serial layer off by default; enumeration applies change.
// - Refuse read address when transmit buffer empty, except in count mode after command 0x0c.
// - Refuse write bytes that cannot be stored.
// - Command 0x0c returns saturated available count.
// - Command 0x0e empties both buffers.
`ifndef UB2I_PARAMS_SVH
`define UB2I_PARAMS_SVH

`define UB2I_BUF_DEPTH 512
`define UB2I_SLAVE_ADDR 7'h22
`define UB2I_GC_ADDR 7'h00
`define UB2I_CMD_SRST 8'h06
`define UB2I_CMD_COUNT 8'h0c
`define UB2I_CMD_FLUSH 8'h0e
`define UB2I_CNT_SAT 8'hff
`define UB2I_IDLE_BYTE 8'hff
`define UB2I_VSL_RST 1'b0
`define UB2I_CLK_MHZ 100
`define UB2I_LAT_MS 16
`define UB2I_LAT_CYCLES (`UB2I_LAT_MS * 1000 * `UB2I_CLK_MHZ)

`endif

// [include/ub2i_pkg.sv]
// Types shared by the bridge design files.
package ub2i_pkg;

  typedef enum {L_IDLE, L_ADDR, L_WR, L_GC, L_ACK, L_RD, L_MACK, L_RDLD} ub2i_link_st_t;

  typedef enum {K_RD, K_WR, K_GC, K_END} ub2i_ack_kind_t;

endpackage : ub2i_pkg

// [rtl/ub2i_byte_buf.sv]
// Byte buffer held in flip-flops with flush, count and head view.
`timescale 1ns/1ps
`default_nettype none
`include "ub2i_params.svh"
module ub2i_byte_buf
#(
  parameter int DEPTH = `UB2I_BUF_DEPTH,
  parameter int AW    = $clog2(DEPTH),
  parameter int CW    = $clog2(DEPTH + 1)
)
(
  // Clock and reset.
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_n,
  // Write side.
  input  wire logic          i_flush,
  input  wire logic          i_push,
  input  wire logic [7:0]    i_push_data,
  // Read side.
  input  wire logic          i_pop,
  output logic      [7:0]    o_head,
  output logic      [CW-1:0] o_count,
  output logic               o_full,
  output logic               o_empty
);
  logic [7:0]    mem_reg [DEPTH];
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] rd_next;
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] wr_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          do_push;
  logic          do_pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1))
      return '0;
    return p + AW'(1);
  endfunction : ptr_inc

  assign o_empty = (cnt_reg == '0);
  assign o_full  = (cnt_reg == CW'(DEPTH));
  assign o_count = cnt_reg;
  assign o_head  = mem_reg[rd_reg];
  assign do_push = i_push & ~o_full & ~i_flush;
  assign do_pop  = i_pop & ~o_empty & ~i_flush;

  always_comb
  begin
    rd_next  = do_pop ? ptr_inc(rd_reg) : rd_reg;
    wr_next  = do_push ? ptr_inc(wr_reg) : wr_reg;
    cnt_next = cnt_reg + CW'(do_push) - CW'(do_pop);
    if (i_flush)
    begin
      rd_next  = '0;
      wr_next  = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_reg  <= '0;
      wr_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      rd_reg  <= rd_next;
      wr_reg  <= wr_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; only the pointers define what is valid.
  always_ff @(posedge i_core_clk)
  begin
    if (do_push)
      mem_reg[wr_reg] <= i_push_data;
  end

endmodule : ub2i_byte_buf
`default_nettype wire

// [rtl/ub2i_bridge.sv]
// Top of the USB to two-wire slave data bridge with its link-side slave.
`timescale 1ns/1ps
`default_nettype none
`include "ub2i_params.svh"
module ub2i_bridge
#(
  parameter int         DEPTH      = `UB2I_BUF_DEPTH,
  parameter int         LAT_CYCLES = `UB2I_LAT_CYCLES,
  parameter logic [6:0] SLAVE_ADDR = `UB2I_SLAVE_ADDR
)
(
  // Clocks and reset.
  input  wire logic       i_core_clk,
  input  wire logic       i_link_clk,
  input  wire logic       i_rst_n,
  // Host to device byte stream.
  input  wire logic       i_usb_out_valid,
  input  wire logic [7:0] i_usb_out_data,
  output logic            o_usb_out_ready,
  // Device to host byte stream.
  output logic            o_usb_in_valid,
  output logic      [7:0] o_usb_in_data,
  input  wire logic       i_usb_in_ready,
  // Enumeration and configuration memory.
  input  wire logic       i_usb_enum,
  input  wire logic       i_cfg_vsl_bit,
  output logic            o_virtual_serial_layer_en,
  // Two-wire slave pins.
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int TW = $clog2(LAT_CYCLES + 1);

  // Core domain.
  logic [3:0]    csy1_reg;
  logic [3:0]    csy2_reg;
  logic [3:0]    csy3_reg;
  logic [3:0]    cev;
  logic          op_d1_reg;
  logic          op_d1_next;
  logic          op_d2_reg;
  logic          op_d2_next;
  logic          ack_t_reg;
  logic          ack_t_next;
  logic          tx_av_reg;
  logic          tx_av_next;
  logic          rx_sp_reg;
  logic          rx_sp_next;
  logic [7:0]    tx_out_reg;
  logic [7:0]    tx_out_next;
  logic [7:0]    cnt_reg;
  logic [7:0]    cnt_next;
  logic          out_rdy_reg;
  logic          out_rdy_next;
  logic          in_vld_reg;
  logic          in_vld_next;
  logic [7:0]    in_dat_reg;
  logic [7:0]    in_dat_next;
  logic          drain_reg;
  logic          drain_next;
  logic          vsl_reg;
  logic          vsl_next;
  logic [TW-1:0] tim_reg;
  logic [TW-1:0] tim_next;
  logic [7:0]    tx_head;
  logic [7:0]    rx_head;
  logic [CW-1:0] tx_cnt;
  logic [CW-1:0] rx_cnt;
  logic          tx_full;
  logic          tx_empty;
  logic          rx_full;
  logic          rx_empty;
  logic          tx_push;
  logic          rx_pop;

  // Link domain.
  logic [4:0]                lsy1_reg;
  logic [4:0]                lsy2_reg;
  logic [1:0]                lsd_reg;
  ub2i_pkg::ub2i_link_st_t   ln_st_reg;
  ub2i_pkg::ub2i_link_st_t   ln_st_next;
  ub2i_pkg::ub2i_ack_kind_t  kind_reg;
  ub2i_pkg::ub2i_ack_kind_t  kind_next;
  logic [2:0]                bit_reg;
  logic [2:0]                bit_next;
  logic [7:0]                sh_reg;
  logic [7:0]                sh_next;
  logic [7:0]                rxb_reg;
  logic [7:0]                rxb_next;
  logic                      oe_reg;
  logic                      oe_next;
  logic                      ph_reg;
  logic                      ph_next;
  logic                      ackok_reg;
  logic                      ackok_next;
  logic                      cmode_reg;
  logic                      cmode_next;
  logic                      pop_t_reg;
  logic                      pop_t_next;
  logic                      push_t_reg;
  logic                      push_t_next;
  logic                      cnt_t_reg;
  logic                      cnt_t_next;
  logic                      flush_t_reg;
  logic                      flush_t_next;
  logic                      scl_s;
  logic                      sda_s;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_det;
  logic                      stop_det;
  logic                      pend;
  logic                      rd_real;
  logic [7:0]                rd_byte;
  logic [7:0]                rx_in;

  function automatic logic [7:0] sat8(input logic [CW-1:0] n);
    if (n > CW'(255))
      return `UB2I_CNT_SAT;
    return 8'(n);
  endfunction : sat8

  ub2i_byte_buf #(.DEPTH(DEPTH)) u_tx_buf (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_flush     (cev[3]),
    .i_push      (tx_push),
    .i_push_data (i_usb_out_data),
    .i_pop       (cev[0]),
    .o_head      (tx_head),
    .o_count     (tx_cnt),
    .o_full      (tx_full),
    .o_empty     (tx_empty)
  );

  ub2i_byte_buf #(.DEPTH(DEPTH)) u_rx_buf (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_flush     (cev[3]),
    .i_push      (cev[1]),
    .i_push_data (rxb_reg),
    .i_pop       (rx_pop),
    .o_head      (rx_head),
    .o_count     (rx_cnt),
    .o_full      (rx_full),
    .o_empty     (rx_empty)
  );

  // Link toggles: bit 0 pop, 1 push, 2 count request, 3 flush.
  assign cev     = csy2_reg ^ csy3_reg;
  assign tx_push = i_usb_out_valid & out_rdy_reg;

  always_comb
  begin
    op_d1_next   = |cev[2:0];
    op_d2_next   = op_d1_reg;
    // The answer toggle lags data and levels so the link sees them settled.
    ack_t_next   = ack_t_reg ^ op_d2_reg;
    tx_av_next   = ~tx_empty;
    rx_sp_next   = ~rx_full;
    tx_out_next  = tx_head;
    cnt_next     = cev[2] ? sat8(tx_cnt) : cnt_reg;
    out_rdy_next = (tx_cnt < CW'(DEPTH - 1)) || ((tx_cnt == CW'(DEPTH - 1)) && !tx_push);
    vsl_next     = i_usb_enum ? i_cfg_vsl_bit : vsl_reg;
    rx_pop       = 1'b0;
    in_vld_next  = in_vld_reg;
    in_dat_next  = in_dat_reg;
    drain_next   = drain_reg;
    tim_next     = tim_reg;
    if (in_vld_reg && i_usb_in_ready)
      in_vld_next = 1'b0;
    if (!drain_reg)
    begin
      if (rx_full || (!rx_empty && (tim_reg == TW'(LAT_CYCLES - 1))))
        drain_next = 1'b1;
      tim_next = rx_empty ? '0 : tim_reg + TW'(1);
    end
    else
    begin
      tim_next = '0;
      if (!rx_empty && (!in_vld_reg || i_usb_in_ready))
      begin
        rx_pop      = 1'b1;
        in_vld_next = 1'b1;
        in_dat_next = rx_head;
      end
      else if (rx_empty)
        drain_next = 1'b0;
    end
    if (cev[3])
    begin
      drain_next = 1'b0;
      tim_next   = '0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      csy1_reg    <= '0;
      csy2_reg    <= '0;
      csy3_reg    <= '0;
      op_d1_reg   <= 1'b0;
      op_d2_reg   <= 1'b0;
      ack_t_reg   <= 1'b0;
      tx_av_reg   <= 1'b0;
      rx_sp_reg   <= 1'b0;
      tx_out_reg  <= '0;
      cnt_reg     <= '0;
      out_rdy_reg <= 1'b0;
      in_vld_reg  <= 1'b0;
      in_dat_reg  <= '0;
      drain_reg   <= 1'b0;
      vsl_reg     <= `UB2I_VSL_RST;
      tim_reg     <= '0;
    end
    else
    begin
      csy1_reg    <= {flush_t_reg, cnt_t_reg, push_t_reg, pop_t_reg};
      csy2_reg    <= csy1_reg;
      csy3_reg    <= csy2_reg;
      op_d1_reg   <= op_d1_next;
      op_d2_reg   <= op_d2_next;
      ack_t_reg   <= ack_t_next;
      tx_av_reg   <= tx_av_next;
      rx_sp_reg   <= rx_sp_next;
      tx_out_reg  <= tx_out_next;
      cnt_reg     <= cnt_next;
      out_rdy_reg <= out_rdy_next;
      in_vld_reg  <= in_vld_next;
      in_dat_reg  <= in_dat_next;
      drain_reg   <= drain_next;
      vsl_reg     <= vsl_next;
      tim_reg     <= tim_next;
    end
  end

  // Link side: bits of lsy are scl, sda, answer toggle, data present, space free.
  assign scl_s     = lsy2_reg[0];
  assign sda_s     = lsy2_reg[1];
  assign scl_rise  = scl_s & ~lsd_reg[0];
  assign scl_fall  = ~scl_s & lsd_reg[0];
  assign start_det = scl_s & lsd_reg[0] & ~sda_s & lsd_reg[1];
  assign stop_det  = scl_s & lsd_reg[0] & sda_s & ~lsd_reg[1];
  assign pend      = pop_t_reg ^ push_t_reg ^ cnt_t_reg ^ lsy2_reg[2];
  assign rx_in     = {sh_reg[6:0], sda_s};
  assign rd_real   = ~cmode_reg & ~pend & lsy2_reg[3];
  assign rd_byte   = cmode_reg ? cnt_reg : (rd_real ? tx_out_reg : `UB2I_IDLE_BYTE);

  always_comb
  begin
    ln_st_next   = ln_st_reg;
    kind_next    = kind_reg;
    bit_next     = bit_reg;
    sh_next      = sh_reg;
    rxb_next     = rxb_reg;
    oe_next      = oe_reg;
    ph_next      = ph_reg;
    ackok_next   = ackok_reg;
    cmode_next   = cmode_reg;
    pop_t_next   = pop_t_reg;
    push_t_next  = push_t_reg;
    cnt_t_next   = cnt_t_reg;
    flush_t_next = flush_t_reg;
    if (start_det)
    begin
      ln_st_next = ub2i_pkg::L_ADDR;
      bit_next   = '0;
      oe_next    = 1'b0;
    end
    else if (stop_det)
    begin
      ln_st_next = ub2i_pkg::L_IDLE;
      oe_next    = 1'b0;
    end
    else
    begin
      case (ln_st_reg)
        ub2i_pkg::L_ADDR, ub2i_pkg::L_WR, ub2i_pkg::L_GC:
          if (scl_rise)
          begin
            sh_next  = rx_in;
            bit_next = bit_reg + 3'd1;
            if (bit_reg == 3'd7)
            begin
              ln_st_next = ub2i_pkg::L_ACK;
              ph_next    = 1'b0;
              ackok_next = 1'b0;
              kind_next  = ub2i_pkg::K_END;
              if (ln_st_reg == ub2i_pkg::L_ADDR)
              begin
                if ((sh_reg[6:0] == SLAVE_ADDR) && sda_s)
                begin
                  kind_next  = ub2i_pkg::K_RD;
                  ackok_next = ~pend & (cmode_reg | lsy2_reg[3]);
                end
                else if (sh_reg[6:0] == SLAVE_ADDR)
                begin
                  kind_next  = ub2i_pkg::K_WR;
                  ackok_next = ~pend & lsy2_reg[4];
                end
                else if ((sh_reg[6:0] == `UB2I_GC_ADDR) && !sda_s)
                begin
                  kind_next  = ub2i_pkg::K_GC;
                  ackok_next = 1'b1;
                end
              end
              else if (ln_st_reg == ub2i_pkg::L_WR)
              begin
                kind_next  = ub2i_pkg::K_WR;
                ackok_next = ~pend & lsy2_reg[4];
                if (!pend && lsy2_reg[4])
                begin
                  rxb_next    = rx_in;
                  push_t_next = ~push_t_reg;
                end
              end
              else
              begin
                ackok_next = 1'b1;
                if (rx_in == `UB2I_CMD_COUNT)
                begin
                  cnt_t_next = ~cnt_t_reg;
                  cmode_next = 1'b1;
                end
                if ((rx_in == `UB2I_CMD_FLUSH) || (rx_in == `UB2I_CMD_SRST))
                  flush_t_next = ~flush_t_reg;
              end
            end
          end
        ub2i_pkg::L_ACK:
          if (scl_fall && !ph_reg)
          begin
            ph_next = 1'b1;
            oe_next = ackok_reg;
          end
          else if (scl_fall)
          begin
            oe_next    = 1'b0;
            bit_next   = '0;
            ln_st_next = ub2i_pkg::L_IDLE;
            if (ackok_reg)
            begin
              case (kind_reg)
                ub2i_pkg::K_RD:
                begin
                  sh_next    = rd_byte;
                  oe_next    = ~rd_byte[7];
                  pop_t_next = pop_t_reg ^ rd_real;
                  ln_st_next = ub2i_pkg::L_RD;
                end
                ub2i_pkg::K_WR: ln_st_next = ub2i_pkg::L_WR;
                ub2i_pkg::K_GC: ln_st_next = ub2i_pkg::L_GC;
                default: ln_st_next = ub2i_pkg::L_IDLE;
              endcase
            end
          end
        ub2i_pkg::L_RD:
          if (scl_rise)
          begin
            if (bit_reg == 3'd7)
              ln_st_next = ub2i_pkg::L_MACK;
            else
              bit_next = bit_reg + 3'd1;
          end
          else if (scl_fall)
            oe_next = ~sh_reg[3'd7 - bit_reg];
        ub2i_pkg::L_MACK:
          if (scl_fall)
            oe_next = 1'b0;
          else if (scl_rise && !sda_s)
            ln_st_next = ub2i_pkg::L_RDLD;
          else if (scl_rise)
          begin
            ln_st_next = ub2i_pkg::L_IDLE;
            cmode_next = 1'b0;
          end
        ub2i_pkg::L_RDLD:
          if (scl_fall)
          begin
            sh_next    = rd_byte;
            oe_next    = ~rd_byte[7];
            pop_t_next = pop_t_reg ^ rd_real;
            bit_next   = '0;
            ln_st_next = ub2i_pkg::L_RD;
          end
        default: ln_st_next = ub2i_pkg::L_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lsy1_reg    <= '0;
      lsy2_reg    <= '0;
      lsd_reg     <= '0;
      ln_st_reg   <= ub2i_pkg::L_IDLE;
      kind_reg    <= ub2i_pkg::K_END;
      bit_reg     <= '0;
      sh_reg      <= '0;
      rxb_reg     <= '0;
      oe_reg      <= 1'b0;
      ph_reg      <= 1'b0;
      ackok_reg   <= 1'b0;
      cmode_reg   <= 1'b0;
      pop_t_reg   <= 1'b0;
      push_t_reg  <= 1'b0;
      cnt_t_reg   <= 1'b0;
      flush_t_reg <= 1'b0;
    end
    else
    begin
      lsy1_reg    <= {rx_sp_reg, tx_av_reg, ack_t_reg, i_sda, i_scl};
      lsy2_reg    <= lsy1_reg;
      lsd_reg     <= lsy2_reg[1:0];
      ln_st_reg   <= ln_st_next;
      kind_reg    <= kind_next;
      bit_reg     <= bit_next;
      sh_reg      <= sh_next;
      rxb_reg     <= rxb_next;
      oe_reg      <= oe_next;
      ph_reg      <= ph_next;
      ackok_reg   <= ackok_next;
      cmode_reg   <= cmode_next;
      pop_t_reg   <= pop_t_next;
      push_t_reg  <= push_t_next;
      cnt_t_reg   <= cnt_t_next;
      flush_t_reg <= flush_t_next;
    end
  end

  // Data pin only ever pulls low; there is no clock output at all.
  assign o_sda_out                 = 1'b0;
  assign o_sda_oe                  = oe_reg;
  assign o_usb_out_ready           = out_rdy_reg;
  assign o_usb_in_valid            = in_vld_reg;
  assign o_usb_in_data             = in_dat_reg;
  assign o_virtual_serial_layer_en = vsl_reg;

endmodule : ub2i_bridge
`default_nettype wire

// [tb/ub2i_bridge_checker.sv]
// Concurrent checks on the bridge's ports.
`timescale 1ns/1ps
`default_nettype none
module ub2i_bridge_checker
(
  // Clocks and reset.
  input wire logic       i_core_clk,
  input wire logic       i_link_clk,
  input wire logic       i_rst_n,
  // Byte streams and enumeration.
  input wire logic       i_usb_out_valid,
  input wire logic       o_usb_out_ready,
  input wire logic       o_usb_in_valid,
  input wire logic [7:0] o_usb_in_data,
  input wire logic       i_usb_in_ready,
  input wire logic       i_usb_enum,
  input wire logic       i_cfg_vsl_bit,
  input wire logic       o_virtual_serial_layer_en,
  // Two-wire pins.
  input wire logic       i_scl,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe
);
  // Counts link cycles with the clock line high, so an idle bus can be recognised.
  logic [4:0] scl_hi_reg;
  logic [4:0] scl_hi_next;

  always_comb
  begin
    scl_hi_next = scl_hi_reg;
    if (!i_scl)
      scl_hi_next = 5'h00;
    else if (scl_hi_reg != 5'h1f)
      scl_hi_next = scl_hi_reg + 5'h01;
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n)
    if (!i_rst_n)
      scl_hi_reg <= 5'h00;
    else
      scl_hi_reg <= scl_hi_next;

  a_sda_open_drain: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    o_sda_out == 1'b0) else $error("data pin driven high");
  a_oe_rise_low: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    $rose(o_sda_oe) |-> !i_scl) else $error("data pulled while clock high");
  a_oe_stable_high: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    i_scl && $past(i_scl) && $past(i_scl, 2) |-> $stable(o_sda_oe))
    else $error("data drive changed while clock high");
  a_oe_idle_free: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
    scl_hi_reg >= 5'h14 |-> !o_sda_oe) else $error("data held on idle bus");
  a_in_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_usb_in_valid && !i_usb_in_ready |=> o_usb_in_valid && $stable(o_usb_in_data))
    else $error("host byte dropped before taken");
  a_enum_sample: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_usb_enum |=> o_virtual_serial_layer_en == $past(i_cfg_vsl_bit))
    else $error("option not sampled at enumeration");
  a_vsl_steady: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_usb_enum |=> $stable(o_virtual_serial_layer_en)) else $error("option moved");
  a_ready_fall_push: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(o_usb_out_ready) |-> $past(i_usb_out_valid && o_usb_out_ready))
    else $error("ready fell without a push");

  c_in_take: cover property (@(posedge i_core_clk) o_usb_in_valid && i_usb_in_ready);
  c_tx_full: cover property (@(posedge i_core_clk) $fell(o_usb_out_ready));
  c_sda_pull: cover property (@(posedge i_link_clk) $rose(o_sda_oe));
endmodule : ub2i_bridge_checker

bind ub2i_bridge ub2i_bridge_checker i_ub2i_bridge_checker
(
  .i_core_clk, .i_link_clk, .i_rst_n, .i_usb_out_valid, .o_usb_out_ready,
  .o_usb_in_valid, .o_usb_in_data, .i_usb_in_ready, .i_usb_enum, .i_cfg_vsl_bit,
  .o_virtual_serial_layer_en, .i_scl, .o_sda_out, .o_sda_oe
);
`default_nettype wire

// [tb/ub2i_i2c_master.sv]
// Behavioural two-wire bus master facing the bridge's slave pins.
`timescale 1ns/1ps
`default_nettype none
module ub2i_i2c_master
#(
  parameter int HALF_NS = 200,
  parameter int GAP_NS  = 480
)
(
  // Resolved data line.
  input  wire logic i_sda_line,
  // Clock line and data pull-down.
  output logic      o_scl,
  output logic      o_sda_low
);
  initial
  begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // Data changes only while the clock line is low.
  task automatic put_bit(input logic b);
    #40 o_sda_low = ~b;
    #(HALF_NS - 40) o_scl = 1'b1;
    #(HALF_NS) o_scl = 1'b0;
  endtask : put_bit

  task automatic get_bit(output logic b);
    #40 o_sda_low = 1'b0;
    #(HALF_NS - 40) o_scl = 1'b1;
    #(HALF_NS / 2) b = i_sda_line;
    #(HALF_NS / 2) o_scl = 1'b0;
  endtask : get_bit

  task automatic bus_start;
    #40 o_sda_low = 1'b0;
    #(HALF_NS - 40) o_scl = 1'b1;
    #(HALF_NS) o_sda_low = 1'b1;
    #(HALF_NS) o_scl = 1'b0;
  endtask : bus_start

  task automatic bus_stop;
    #40 o_sda_low = 1'b1;
    #(HALF_NS - 40) o_scl = 1'b1;
    #(HALF_NS) o_sda_low = 1'b0;
    #(HALF_NS);
  endtask : bus_stop

  // The gap with the clock low lets the slave's buffers settle between bytes.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i]);
    get_bit(v);
    ack = ~v;
    #(GAP_NS);
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] b, input logic more);
    for (int i = 7; i >= 0; i--)
      get_bit(b[i]);
    put_bit(~more);
    #(GAP_NS);
  endtask : recv_byte
endmodule : ub2i_i2c_master
`default_nettype wire

// [tb/tb_ub2i_bridge.sv]
// Self-checking bench for the USB to two-wire slave data bridge.
`timescale 1ns/1ps
`default_nettype none
module tb_ub2i_bridge;
  localparam int         DEPTH = 8;
  localparam int         LAT   = 8000;
  localparam logic [6:0] ADDR  = 7'h22;
  logic       core_clk, link_clk, rst_n, out_valid, out_ready, in_valid, in_ready;
  logic       usb_enum, cfg_bit, vsl_en, scl, m_low, sda_out, sda_oe;
  logic [7:0] out_data, in_data;
  logic [7:0] wr_b [0:15];
  logic [7:0] rd_b [0:15];
  logic [7:0] rx_q [$];
  wire        sda_line;
  int         n_fail, checks;

  // The data line has a pull-up; either party may pull it low.
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~m_low;

  ub2i_bridge #(.DEPTH(DEPTH), .LAT_CYCLES(LAT), .SLAVE_ADDR(ADDR)) i_ub2i_bridge (
    .i_core_clk(core_clk), .i_link_clk(link_clk), .i_rst_n(rst_n),
    .i_usb_out_valid(out_valid), .i_usb_out_data(out_data), .o_usb_out_ready(out_ready),
    .o_usb_in_valid(in_valid), .o_usb_in_data(in_data), .i_usb_in_ready(in_ready),
    .i_usb_enum(usb_enum), .i_cfg_vsl_bit(cfg_bit), .o_virtual_serial_layer_en(vsl_en),
    .i_scl(scl), .i_sda(sda_line), .o_sda_out(sda_out), .o_sda_oe(sda_oe));
  ub2i_i2c_master i_ub2i_i2c_master (.i_sda_line(sda_line), .o_scl(scl), .o_sda_low(m_low));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  always @(posedge core_clk)
    if (rst_n && in_valid === 1'b1 && in_ready === 1'b1)
      rx_q.push_back(in_data);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic push_seq(input int n);
    int k;
    out_valid = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      out_data = wr_b[i];
      for (k = 0; out_ready !== 1'b1 && k < 200; k++)
        @(negedge core_clk);
      check(8'(out_ready), 8'h01);
      if (out_ready !== 1'b1)
        report_and_stop();
      @(negedge core_clk);
    end
    out_valid = 1'b0;
  endtask : push_seq

  task automatic wait_rx(input int n, input int bound, output int took);
    for (took = 0; rx_q.size() < n; took++)
    begin
      @(negedge core_clk);
      if (took > bound)
      begin
        check(8'(rx_q.size()), 8'(n));
        report_and_stop();
      end
    end
  endtask : wait_rx

  task automatic wr_burst(input logic [6:0] a, input int n, output logic a_ack, output int n_ok);
    logic ack;
    n_ok = 0;
    i_ub2i_i2c_master.bus_start();
    i_ub2i_i2c_master.send_byte({a, 1'b0}, a_ack);
    ack = a_ack;
    for (int i = 0; i < n && ack === 1'b1; i++)
    begin
      i_ub2i_i2c_master.send_byte(wr_b[i], ack);
      n_ok += (ack === 1'b1) ? 1 : 0;
    end
    i_ub2i_i2c_master.bus_stop();
    @(negedge core_clk);
  endtask : wr_burst

  task automatic rd_burst(input int n, output logic a_ack);
    i_ub2i_i2c_master.bus_start();
    i_ub2i_i2c_master.send_byte({ADDR, 1'b1}, a_ack);
    if (a_ack === 1'b1)
      for (int i = 0; i < n; i++)
        i_ub2i_i2c_master.recv_byte(rd_b[i], i < n - 1);
    i_ub2i_i2c_master.bus_stop();
    @(negedge core_clk);
  endtask : rd_burst

  task automatic gc_cmd(input logic [7:0] c);
    logic a, b;
    i_ub2i_i2c_master.bus_start();
    i_ub2i_i2c_master.send_byte(8'h00, a);
    i_ub2i_i2c_master.send_byte(c, b);
    i_ub2i_i2c_master.bus_stop();
    check(8'({a, b}), 8'h03);
    repeat (20) @(negedge core_clk);
  endtask : gc_cmd

  task automatic sc_reset;
    check(8'({out_ready, in_valid, vsl_en, sda_oe}), 8'h08);
  endtask : sc_reset

  task automatic sc_tx_path;
    logic a;
    rd_burst(1, a);
    check(8'(a), 8'h00);
    wr_b[0] = 8'ha5;
    wr_b[1] = 8'h3c;
    wr_b[2] = 8'h01;
    push_seq(3);
    repeat (20) @(negedge core_clk);
    rd_burst(3, a);
    check(8'(a), 8'h01);
    for (int i = 0; i < 3; i++)
      check(rd_b[i], wr_b[i]);
    rd_burst(1, a);
    check(8'(a), 8'h00);
  endtask : sc_tx_path

  task automatic sc_count_flush;
    logic a;
    for (int i = 0; i < 8; i++)
      wr_b[i] = 8'h40 + 8'(i);
    push_seq(5);
    repeat (20) @(negedge core_clk);
    gc_cmd(8'h0c);
    rd_burst(1, a);
    check(rd_b[0], 8'h05);
    push_seq(DEPTH - 5);
    repeat (2) @(negedge core_clk);
    check(8'(out_ready), 8'h00);
    gc_cmd(8'h0c);
    rd_burst(1, a);
    check(rd_b[0], 8'(DEPTH));
    gc_cmd(8'h0e);
    check(8'(out_ready), 8'h01);
    rd_burst(1, a);
    check(8'(a), 8'h00);
  endtask : sc_count_flush

  task automatic sc_rx_full;
    logic a;
    int   n, took;
    for (int i = 0; i < 10; i++)
      wr_b[i] = 8'h90 + 8'(i);
    rx_q.delete();
    // The output register frees one place, so DEPTH + 1 bytes fit.
    wr_burst(ADDR, 10, a, n);
    check(8'(a), 8'h01);
    check(8'(n), 8'(DEPTH + 1));
    for (took = 0; in_valid !== 1'b1 && took < 1000; took++)
      @(negedge core_clk);
    check(8'(took < 1000), 8'h01);
    if (took >= 1000)
      report_and_stop();
    in_ready = 1'b1;
    wait_rx(DEPTH + 1, 100, took);
    for (int i = 0; i <= DEPTH; i++)
      check(rx_q[i], wr_b[i]);
  endtask : sc_rx_full

  task automatic sc_latency;
    logic a;
    int   n, took;
    for (int k = 0; k < 2; k++)
    begin
      rx_q.delete();
      wr_b[0] = 8'h77 + 8'(k);
      wr_burst(ADDR, 1, a, n);
      wait_rx(1, LAT + 500, took);
      check(8'(took > LAT - 300), 8'h01);
      check(rx_q[0], wr_b[0]);
    end
  endtask : sc_latency

  task automatic sc_enum;
    cfg_bit = 1'b1;
    usb_enum = 1'b1;
    @(negedge core_clk);
    usb_enum = 1'b0;
    cfg_bit = 1'b0;
    repeat (3) @(negedge core_clk);
    check(8'(vsl_en), 8'h01);
    usb_enum = 1'b1;
    @(negedge core_clk);
    usb_enum = 1'b0;
    @(negedge core_clk);
    check(8'(vsl_en), 8'h00);
  endtask : sc_enum

  initial
  begin
    n_fail = 0;
    checks = 0;
    rst_n = 1'b0;
    out_valid = 1'b0;
    out_data = 8'h00;
    in_ready = 1'b0;
    usb_enum = 1'b0;
    cfg_bit = 1'b0;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge core_clk);
    sc_reset();
    sc_tx_path();
    sc_count_flush();
    sc_rx_full();
    sc_latency();
    sc_enum();
    report_and_stop();
  end
endmodule : tb_ub2i_bridge
`default_nettype wire
